// ==== hdl/csc_cfg.svh ====
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH
// ============================================================
// Register byte offsets
`define CSC_ADDR_CTRL 8'h00
`define CSC_ADDR_DLY 8'h04
`define CSC_ADDR_DUR 8'h08
`define CSC_ADDR_PHASE 8'h0C
`define CSC_ADDR_STATUS 8'h10
// ============================================================
// Control register fields
`define CSC_CTRL_EXT_CLAMP 0
`define CSC_CTRL_CLAMP_LVL 1
`define CSC_CTRL_EXT_CLK 2
`define CSC_CTRL_SYNC_POL 3
`define CSC_CTRL_PWRDN 4
`define CSC_CTRL_W 5
// ============================================================
// Status register fields
`define CSC_STAT_CLAMP 0
`define CSC_STAT_EXT_CLK 1
`define CSC_STAT_SLICER 2
`define CSC_STAT_INVERT 3
// ============================================================
// Pin vector positions
`define CSC_PIN_LSYNC 0
`define CSC_PIN_CLAMP 1
`define CSC_PIN_SOG 2
`define CSC_PIN_EXTCK 3
`define CSC_PIN_INV 4
`define CSC_PIN_W 5
// ============================================================
// Reset values and timing
`define CSC_CTRL_RST 5'h00
`define CSC_DLY_RST 8'h04
`define CSC_DUR_RST 8'h0A
`define CSC_PHASE_RST 3'h0
`define CSC_INT_HALF_M1 4'h1
`define CSC_CNT_ZERO 8'h00
`define CSC_CNT_ONE 8'h01
`define CSC_WORD_ZERO 32'h00000000
`endif

// ==== hdl/csc_clamp_seq.sv ====
`timescale 1ns/1ps
`include "csc_cfg.svh"
// ============================================================
// Internal clamp window: delay, then duration, in pixel ticks
module csc_clamp_seq
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic tick,
   input wire logic trail,
   input csc_pkg::csc_count_t dly,
   input csc_pkg::csc_count_t dur,
   output logic window
);
   import csc_pkg::*;

   csc_state_t state_reg; // Sequencer state
   csc_state_t state_next;
   csc_count_t cnt_reg; // Remaining ticks of current phase
   csc_count_t cnt_next;

   // ============================================================
   // Next state; a new trailing edge always restarts the window
   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      if (trail)
      begin
         state_next = CSC_DELAY;
         cnt_next = dly;
      end
      else
      begin
         case (state_reg)
            CSC_DELAY:
            begin
               if (cnt_reg == `CSC_CNT_ZERO)
               begin
                  state_next = (dur == `CSC_CNT_ZERO) ? CSC_IDLE : CSC_HOLD;
                  cnt_next = dur;
               end
               else if (tick)
                  cnt_next = cnt_reg - `CSC_CNT_ONE;
            end
            CSC_HOLD:
            begin
               if (cnt_reg == `CSC_CNT_ZERO)
                  state_next = CSC_IDLE;
               else if (tick)
                  cnt_next = cnt_reg - `CSC_CNT_ONE;
            end
            default:
               state_next = CSC_IDLE;
         endcase
      end
   end

   // ============================================================
   // State registers
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_reg <= CSC_IDLE;
         cnt_reg <= `CSC_CNT_ZERO;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   assign window = (state_reg == CSC_HOLD) && (cnt_reg != `CSC_CNT_ZERO);

   // ============================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence s_start;
      trail && (dly != `CSC_CNT_ZERO);
   endsequence
   sequence s_delay_run;
      (state_reg == CSC_DELAY) && !window;
   endsequence

   chk_delay_first: assert property (s_start |=> s_delay_run)
      else $error("window opened without delay");
   chk_window_state: assert property (window |-> state_reg == CSC_HOLD)
      else $error("window outside hold");
   chk_hold_tick: assert property (window && tick && !trail |=>
      cnt_reg == $past(cnt_reg) - `CSC_CNT_ONE)
      else $error("duration not counting ticks");
endmodule

// ==== hdl/csc_pkg.sv ====
// ============================================================
// Shared types
package csc_pkg;
   // Clamp window sequencer states
   typedef enum logic [1:0] {CSC_IDLE, CSC_DELAY, CSC_HOLD} csc_state_t;
   // Pixel count for delay and duration
   typedef logic [7:0] csc_count_t;
   // APB data word
   typedef logic [31:0] csc_word_t;
endpackage

// ==== hdl/csc_top.sv ====
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "csc_cfg.svh"
// Overview of operation
// - External clamp only when enable bit set
// - Otherwise count delay, duration from trailing edge
// - Clamp pin sense set by level bit
// - Green sync slicer runs in power-down
// - External clock select uses external pixel clock
// - Phase adjust still works on external clock
// - Invert input shifts sampling half a period
// - Odd pixels, then inverted even next frame
// - Sync polarity picks trailing edge
module csc_top
#(
   parameter int PHASE_W = 3
)
(
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input csc_pkg::csc_word_t PWDATA,
   output csc_pkg::csc_word_t PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic LINE_SYNC_IN,
   input wire logic CLAMP_PIN_IN,
   input wire logic GREEN_SYNC_SLICER_IN,
   input wire logic EXTERNAL_PIXEL_CLOCK_IN,
   input wire logic SAMPLE_CLOCK_INVERT,
   output logic GREEN_SYNC_SLICER_OUT,
   output logic PIXEL_CLOCK_OUT,
   output logic SAMPLE_STROBE_OUT,
   output logic CLAMP_WINDOW_OUT
);
   import csc_pkg::*;

   localparam int TAPS = 2 ** PHASE_W; // Phase delay taps

   // Edge detectors on synchronised levels
   function automatic logic is_rise(input logic prev, input logic cur);
      is_rise = cur && !prev;
   endfunction
   function automatic logic is_fall(input logic prev, input logic cur);
      is_fall = prev && !cur;
   endfunction

   // ============================================================
   // Register file
   logic [`CSC_CTRL_W-1:0] ctrl_reg; // Control bits
   logic [`CSC_CTRL_W-1:0] ctrl_next;
   csc_count_t dly_reg; // Clamp delay in pixels
   csc_count_t dly_next;
   csc_count_t dur_reg; // Clamp duration in pixels
   csc_count_t dur_next;
   logic [PHASE_W-1:0] phase_reg; // Sampling phase step
   logic [PHASE_W-1:0] phase_next;
   csc_word_t rdata_reg; // Read data, caught in setup
   csc_word_t rdata_next;
   logic err_reg; // Unmapped access flag
   logic err_next;
   csc_word_t status; // Live status word
   logic pd; // Power-down

   assign pd = ctrl_reg[`CSC_CTRL_PWRDN];

   // ============================================================
   // Synchronisers and pixel logic state
   logic [`CSC_PIN_W-1:0] s1_reg; // First stage, read only by s2
   logic [`CSC_PIN_W-1:0] s2_reg; // Safe levels
   logic [`CSC_PIN_W-1:0] s3_reg; // Previous levels for edges
   logic [3:0] int_cnt_reg; // Internal clock divider
   logic [3:0] int_cnt_next;
   logic int_clk_reg; // Internal free-running clock
   logic int_clk_next;
   logic int_prev_reg; // Internal clock one cycle back
   logic [TAPS-1:0] sr_reg; // Phase delay line
   logic [TAPS-1:0] sr_next;
   logic strobe_next;
   logic pclk_next;
   logic win_next;
   logic sog_next;
   logic sel_ext; // External clock selected
   logic inv; // Inversion request, synchronised
   logic pick; // Sampling edge before phase delay
   logic trail; // Line sync trailing edge
   logic int_window; // Internally timed clamp window
   logic clamp_match; // Clamp pin at its active level

   // Zero wait states: each access ends on its first access cycle
   assign PREADY = 1'b1;

   // ============================================================
   // Register next values; read data latched in the setup cycle
   always_comb
   begin
      ctrl_next = ctrl_reg;
      dly_next = dly_reg;
      dur_next = dur_reg;
      phase_next = phase_reg;
      rdata_next = rdata_reg;
      err_next = err_reg;
      if (PSEL && !PENABLE)
      begin
         err_next = 1'b0;
         case (PADDR)
            `CSC_ADDR_CTRL: rdata_next = {27'h0000000, ctrl_reg};
            `CSC_ADDR_DLY: rdata_next = {24'h000000, dly_reg};
            `CSC_ADDR_DUR: rdata_next = {24'h000000, dur_reg};
            `CSC_ADDR_PHASE:
               rdata_next = {{(32-PHASE_W){1'b0}}, phase_reg};
            `CSC_ADDR_STATUS: rdata_next = status;
            default:
            begin
               // Unmapped: zero data and error
               rdata_next = `CSC_WORD_ZERO;
               err_next = 1'b1;
            end
         endcase
      end
      if (PSEL && PENABLE && PWRITE)
      begin
         case (PADDR)
            `CSC_ADDR_CTRL: ctrl_next = PWDATA[`CSC_CTRL_W-1:0];
            `CSC_ADDR_DLY: dly_next = PWDATA[7:0];
            `CSC_ADDR_DUR: dur_next = PWDATA[7:0];
            `CSC_ADDR_PHASE: phase_next = PWDATA[PHASE_W-1:0];
            default: ;
         endcase
      end
   end

   // ============================================================
   // Register state
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         ctrl_reg <= `CSC_CTRL_RST;
         dly_reg <= `CSC_DLY_RST;
         dur_reg <= `CSC_DUR_RST;
         phase_reg <= `CSC_PHASE_RST;
         rdata_reg <= `CSC_WORD_ZERO;
         err_reg <= 1'b0;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         dly_reg <= dly_next;
         dur_reg <= dur_next;
         phase_reg <= phase_next;
         rdata_reg <= rdata_next;
         err_reg <= err_next;
      end
   end

   assign PRDATA = rdata_reg;
   assign PSLVERR = PSEL && PENABLE && err_reg;

   always_comb
   begin
      status = `CSC_WORD_ZERO;
      status[`CSC_STAT_CLAMP] = CLAMP_WINDOW_OUT;
      status[`CSC_STAT_EXT_CLK] = sel_ext;
      status[`CSC_STAT_SLICER] = GREEN_SYNC_SLICER_OUT;
      status[`CSC_STAT_INVERT] = inv;
   end

   // ============================================================
   // Source and edge selection
   assign sel_ext = ctrl_reg[`CSC_CTRL_EXT_CLK];
   assign inv = s2_reg[`CSC_PIN_INV];
   assign clamp_match =
      s2_reg[`CSC_PIN_CLAMP] == ctrl_reg[`CSC_CTRL_CLAMP_LVL];

   always_comb
   begin
      // inversion samples on the opposite edge
      // inverted frame picks up the other pixels
      if (sel_ext)
         pick = inv ?
            is_fall(s3_reg[`CSC_PIN_EXTCK], s2_reg[`CSC_PIN_EXTCK]) :
            is_rise(s3_reg[`CSC_PIN_EXTCK], s2_reg[`CSC_PIN_EXTCK]);
      else
         pick = inv ? is_fall(int_prev_reg, int_clk_reg) :
            is_rise(int_prev_reg, int_clk_reg);
      // polarity 0 leads on falling, trails on rising
      if (ctrl_reg[`CSC_CTRL_SYNC_POL])
         trail = is_fall(s3_reg[`CSC_PIN_LSYNC], s2_reg[`CSC_PIN_LSYNC]);
      else
         trail = is_rise(s3_reg[`CSC_PIN_LSYNC], s2_reg[`CSC_PIN_LSYNC]);
   end

   // ============================================================
   // Pixel logic next values
   always_comb
   begin
      int_cnt_next = int_cnt_reg + 4'h1;
      int_clk_next = int_clk_reg;
      if (int_cnt_reg == `CSC_INT_HALF_M1)
      begin
         int_cnt_next = 4'h0;
         int_clk_next = !int_clk_reg;
      end
      // phase delay applies to either source
      sr_next = {sr_reg[TAPS-2:0], pick};
      strobe_next = sr_reg[phase_reg] && !pd;
      pclk_next = ((sel_ext ? s2_reg[`CSC_PIN_EXTCK] : int_clk_reg) ^ inv)
         && !pd;
      // pin sense from the level bit
      win_next = !pd && (ctrl_reg[`CSC_CTRL_EXT_CLAMP] ?
         clamp_match : int_window);
      sog_next = s2_reg[`CSC_PIN_SOG];
   end

   // ============================================================
   // Pixel logic registers
   always_ff @(posedge CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         int_cnt_reg <= 4'h0;
         int_clk_reg <= 1'b0;
         int_prev_reg <= 1'b0;
         sr_reg <= '0;
         SAMPLE_STROBE_OUT <= 1'b0;
         PIXEL_CLOCK_OUT <= 1'b0;
         CLAMP_WINDOW_OUT <= 1'b0;
         GREEN_SYNC_SLICER_OUT <= 1'b0;
      end
      else
      begin
         s1_reg <= {SAMPLE_CLOCK_INVERT, EXTERNAL_PIXEL_CLOCK_IN,
            GREEN_SYNC_SLICER_IN, CLAMP_PIN_IN, LINE_SYNC_IN};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         int_cnt_reg <= int_cnt_next;
         int_clk_reg <= int_clk_next;
         int_prev_reg <= int_clk_reg;
         sr_reg <= sr_next;
         SAMPLE_STROBE_OUT <= strobe_next;
         PIXEL_CLOCK_OUT <= pclk_next;
         CLAMP_WINDOW_OUT <= win_next;
         GREEN_SYNC_SLICER_OUT <= sog_next;
      end
   end

   // ============================================================
   // Internal clamp sequencer, counting sampling edges
   csc_clamp_seq u_clamp
   (
      .clk(CLK),
      .rstn(RSTN),
      .tick(pick),
      .trail(trail),
      .dly(dly_reg),
      .dur(dur_reg),
      .window(int_window)
   );

   // ============================================================
   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RSTN);

   sequence s_ext_edge_phase0;
      sel_ext && !inv && !pd && (phase_reg == '0) &&
      is_rise(s3_reg[`CSC_PIN_EXTCK], s2_reg[`CSC_PIN_EXTCK]);
   endsequence
   sequence s_inv_edge_phase0;
      sel_ext && inv && !pd && (phase_reg == '0) &&
      is_fall(s3_reg[`CSC_PIN_EXTCK], s2_reg[`CSC_PIN_EXTCK]);
   endsequence

   chk_ext_clamp_reset: assert property ($rose(RSTN) |->
      !ctrl_reg[`CSC_CTRL_EXT_CLAMP])
      else $error("external clamp enabled after reset");
   chk_internal_clamp: assert property (!ctrl_reg[`CSC_CTRL_EXT_CLAMP] && !pd
      |=> CLAMP_WINDOW_OUT == $past(int_window))
      else $error("clamp not from internal window");
   chk_clamp_sense: assert property (ctrl_reg[`CSC_CTRL_EXT_CLAMP] && !pd
      |=> CLAMP_WINDOW_OUT == $past(clamp_match))
      else $error("clamp pin sense wrong");
   chk_slicer_pd: assert property (pd |-> ##2
      GREEN_SYNC_SLICER_OUT == $past(s1_reg[`CSC_PIN_SOG], 2))
      else $error("slicer stopped in power-down");
   chk_ext_strobe: assert property (s_ext_edge_phase0 ##1 !pd
      |=> SAMPLE_STROBE_OUT)
      else $error("external edge not sampled");
   chk_phase_taps: assert property (!pd && $stable(phase_reg)
      |=> SAMPLE_STROBE_OUT == $past(sr_reg[phase_reg]))
      else $error("phase tap not used");
   chk_inv_strobe: assert property (s_inv_edge_phase0 ##1 !pd
      |=> SAMPLE_STROBE_OUT)
      else $error("inverted edge not sampled");
   chk_trail_pol: assert property (!ctrl_reg[`CSC_CTRL_SYNC_POL] && trail
      |-> s2_reg[`CSC_PIN_LSYNC] && !s3_reg[`CSC_PIN_LSYNC])
      else $error("trailing edge wrong for polarity");
endmodule

// ==== testbench/csc_bench.sv ====
`timescale 1ns/1ps
`include "csc_cfg.svh"
// ============================================================
// Bench: APB host, source model, measured pin timing
module clamp_and_sample_clock_select_bench;
   import csc_pkg::*;
   logic clk = 1'b0; // Pixel-domain clock
   logic rstn = 1'b0; // Reset, active low
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   csc_word_t pwdata = 32'h00;
   csc_word_t prdata;
   logic pready, pslverr, err;
   logic lsync, cpin, slin, xclk, win, pclk, strb, slout;
   logic inv = 1'b0; // Sampling clock invert request
   logic sync_high = 1'b0; // Source model settings
   logic clamp_high = 1'b1;
   logic clamp_on = 1'b0;
   logic ext_on = 1'b0;
   int error_cnt = 0;
   int samples_checked = 0;
   int cycles = 0;
   int a_d, a_w, b_d, b_w, c_d, c_w, nw, np, ns;
   csc_word_t rd; // Last read word
   // ============================================================
   // Design and source
   csc_top dut
   (
      .CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .LINE_SYNC_IN(lsync), .CLAMP_PIN_IN(cpin),
      .GREEN_SYNC_SLICER_IN(slin), .EXTERNAL_PIXEL_CLOCK_IN(xclk),
      .SAMPLE_CLOCK_INVERT(inv), .GREEN_SYNC_SLICER_OUT(slout),
      .PIXEL_CLOCK_OUT(pclk), .SAMPLE_STROBE_OUT(strb),
      .CLAMP_WINDOW_OUT(win)
   );
   csc_source_model src
   (
      .clk(clk), .rstn(rstn), .sync_high(sync_high),
      .clamp_high(clamp_high), .clamp_on(clamp_on), .ext_on(ext_on),
      .line_sync(lsync), .clamp_pin(cpin), .slicer(slin),
      .ext_clk(xclk)
   );
   // ============================================================
   // Clock and hang guard
   always #5 clk = ~clk;
   // The tests need under 3000 cycles; a hang ends the run
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 8000)
      begin
         error_cnt = error_cnt + 1;
         print_verdict();
      end
   end
   // ============================================================
   // Tasks
   // Compare and count; report a mismatch at once
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // One APB transfer; the request holds until pready is seen high
   task automatic apb(input logic [7:0] a, input logic w, input csc_word_t d);
      logic rdy;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      rdy = 1'b0;
      while (rdy !== 1'b1)
      begin
         // Answer taken at the rising edge that samples pready high
         @(posedge clk);
         rdy = pready;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input csc_word_t d);
      apb(a, 1'b1, d);
   endtask
   // Counts over 120 cycles: window high, clock and slicer toggles
   task automatic span();
      logic p, s;
      @(negedge clk);
      p = pclk;
      s = slout;
      nw = 0;
      np = 0;
      ns = 0;
      repeat (120)
      begin
         @(negedge clk);
         nw = nw + (win === 1'b1);
         np = np + (pclk !== p);
         ns = ns + (slout !== s);
         p = pclk;
         s = slout;
      end
   endtask
   // Sync trailing edge to window opening, then window width
   task automatic clamp_meas(output int dl, output int wd);
      dl = 0;
      wd = 0;
      @(negedge clk);
      while (lsync !== sync_high)
         @(negedge clk);
      while (lsync === sync_high)
         @(negedge clk);
      while (win !== 1'b1)
      begin
         @(negedge clk);
         dl = dl + 1;
      end
      while (win === 1'b1)
      begin
         @(negedge clk);
         wd = wd + 1;
      end
   endtask
   // External clock rise to the sampling strobe, in cycles
   task automatic strobe_meas(output int dl);
      dl = 0;
      @(negedge clk);
      while (xclk !== 1'b0)
         @(negedge clk);
      while (xclk === 1'b0)
         @(negedge clk);
      while (strb !== 1'b1)
      begin
         @(negedge clk);
         dl = dl + 1;
      end
   endtask
   // ============================================================
   // Test sequence
   initial
   begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      apb(`CSC_ADDR_CTRL, 1'b0, 32'h00);
      check(rd, 32'h00);
      apb(`CSC_ADDR_DLY, 1'b0, 32'h00);
      check(rd, {24'h000000, `CSC_DLY_RST});
      apb(`CSC_ADDR_DUR, 1'b0, 32'h00);
      check(rd, {24'h000000, `CSC_DUR_RST});
      apb(8'h14, 1'b0, 32'h00);
      check(rd, 32'h00);
      check(err, 32'h01);
      $display("reset values done");
      // Internal window: width and delay follow the registers
      wr(`CSC_ADDR_DLY, 32'h02);
      wr(`CSC_ADDR_DUR, 32'h03);
      clamp_meas(a_d, a_w);
      wr(`CSC_ADDR_DUR, 32'h05);
      clamp_meas(b_d, b_w);
      check(b_w - a_w, 32'h08);
      check(b_d, a_d);
      wr(`CSC_ADDR_DLY, 32'h06);
      clamp_meas(c_d, c_w);
      check(c_d - a_d, 32'h10);
      clamp_on <= 1'b1;
      clamp_meas(b_d, b_w);
      check(b_d, c_d);
      check(b_w, c_w);
      wr(`CSC_ADDR_CTRL, 32'h08);
      sync_high <= 1'b1;
      clamp_meas(b_d, b_w);
      check(b_d, c_d);
      check(b_w, c_w);
      wr(`CSC_ADDR_DUR, 32'h00);
      span();
      span();
      check(nw, 32'h00);
      check(np, 32'h3C);
      check(ns, 32'h1E);
      $display("internal clamp done");
      // External clamp, both pin senses; internal window is off
      wr(`CSC_ADDR_CTRL, 32'h0B);
      clamp_meas(b_d, b_w);
      check(b_d, 32'h07);
      check(b_w, 32'h0C);
      wr(`CSC_ADDR_CTRL, 32'h09);
      clamp_high <= 1'b0;
      clamp_meas(b_d, b_w);
      check(b_d, 32'h07);
      check(b_w, 32'h0C);
      wr(`CSC_ADDR_CTRL, 32'h08);
      clamp_on <= 1'b0;
      $display("external clamp done");
      // External pixel clock, phase and inversion
      wr(`CSC_ADDR_CTRL, 32'h0C);
      ext_on <= 1'b1;
      apb(`CSC_ADDR_STATUS, 1'b0, 32'h00);
      check(rd[1], 1'b1);
      span();
      check(np, 32'h18);
      strobe_meas(a_d);
      wr(`CSC_ADDR_PHASE, 32'h03);
      strobe_meas(b_d);
      check(b_d - a_d, 32'h03);
      wr(`CSC_ADDR_PHASE, 32'h00);
      while (lsync !== sync_high)
         @(negedge clk);
      @(posedge clk);
      inv <= 1'b1;
      repeat (12) @(negedge clk);
      strobe_meas(c_d);
      check(c_d - a_d, 32'h05);
      $display("external clock done");
      wr(`CSC_ADDR_CTRL, 32'h10);
      ext_on <= 1'b0;
      span();
      span();
      check(nw, 32'h00);
      check(np, 32'h00);
      check(ns, 32'h1E);
      $display("power-down done");
      print_verdict();
   end
endmodule

// ==== testbench/csc_source_model.sv ====
`timescale 1ns/1ps
// ============================================================
// Graphics source: line sync, clamp pin, slicer, pixel clock
module csc_source_model
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic sync_high, // Sync pulse level
   input wire logic clamp_high, // Clamp pin active level
   input wire logic clamp_on, // Clamp pin in use
   input wire logic ext_on, // External clock supplied
   output logic line_sync,
   output logic clamp_pin,
   output logic slicer,
   output logic ext_clk
);
   logic [5:0] pos_reg; // Position in a 64-cycle line
   logic [3:0] div_reg; // External clock phase, period 10
   logic porch; // Black level present on the inputs
   // ============================================================
   // Counters
   // A line of 64 is a multiple of the internal period of 4,
   // so every line meets the same internal clock phase
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pos_reg <= 6'h00;
         div_reg <= 4'h0;
      end
      else
      begin
         pos_reg <= pos_reg + 6'h01;
         div_reg <= (div_reg == 4'h9) ? 4'h0 : div_reg + 4'h1;
      end
   end
   // ============================================================
   // Pins
   // Sync pulse in cycles 0 to 7
   assign line_sync = (pos_reg < 6'h08) ? sync_high : !sync_high;
   assign porch = (pos_reg >= 6'h0C) && (pos_reg < 6'h18);
   assign clamp_pin = clamp_on && (porch == clamp_high);
   // Composite sync stand-in, changes every 4 cycles
   assign slicer = pos_reg[2];
   // Pulled down when no external clock is fitted
   assign ext_clk = ext_on && (div_reg < 4'h5);
endmodule
